// ===== verilog/dbadp_data_path.sv
// Data path control: byte counters, selector, command condition, buffers
`default_nettype none
module dbadp_data_path (
  input wire logic ref_clk,
  input wire logic rst,
  input wire dbadp_pkg::dbadp_mode_t mode,
  input wire logic [9:0] ctl_store,
  input wire logic ctl_store_bit9,
  input wire logic int_read_req,
  input wire logic external_read_req_n,
  input wire logic send_transfer,
  input wire logic phase_t1,
  input wire logic bus_input_strobe,
  input wire logic [31:0] bus_in,
  input wire logic load_word_one,
  input wire logic load_word_two,
  input wire logic count_write,
  input wire logic mem_read_pending_n,
  input wire logic cmd_accepted,
  input wire logic mem_select_latch,
  input wire logic [2:0] virt_addr_low,
  input wire logic end_of_block,
  input wire logic drive_word_sent,
  input wire logic drive_byte_in,
  input wire logic [7:0] drive_byte,
  input wire logic out_byte_taken,
  input wire logic last_byte_full,
  input wire logic out_partly_filled,
  input wire dbadp_pkg::dbadp_src_t src,
  output logic [31:0] bus_out,
  output logic bus_drive_en,
  output logic [2:0] bus_source_select,
  output logic cmd_condition,
  output logic cmd_req_pending,
  output logic [31:0] split_byte_count,
  output logic mem_count_zero_n,
  output logic drive_count_zero,
  output logic run_clear,
  output logic xfer_done,
  output logic write_buffers_ready,
  output logic [7:0] input_byte_enable_n,
  output logic virt_addr_bump_n,
  output logic silo_load,
  output logic [7:0] silo_out,
  output logic silo_out_valid,
  output logic silo_full,
  output logic silo_empty
);
  typedef struct packed {
    logic [15:0] drive_cnt;
    logic [15:0] mem_cnt;
    logic mem_zero;
    logic drive_zero;
    logic run_clr;
    logic done;
    logic cmd_pend;
    logic [3:0] fill_cnt;
    logic input_word_two_full;
    logic [31:0] rx_latch;
    logic [31:0] word_one;
    logic [31:0] word_two;
    logic [2:0] va_latch;
    logic [31:0] bus_out;
    logic [4:0] silo_cnt;
    logic [3:0] wr_ptr;
    logic [3:0] rd_ptr;
    logic [7:0] silo_dout;
    logic [2:0] ebl_sync;
  } dbadp_state_t;

  dbadp_state_t st;
  dbadp_state_t next_st;
  logic [7:0] silo_mem [dbadp_pkg::SILO_DEPTH];
  logic [31:0] mux_out;
  logic ext_status_only;
  logic bcnt_selected;
  logic silo_push;
  logic silo_pop;
  logic [7:0] silo_din;
  logic ebl_seen;

  function automatic logic [7:0] byte_of(input logic [31:0] w,
                                         input logic [1:0] idx);
    byte_of = w[idx*8 +: 8];
  endfunction : byte_of

  // Byte counter read decode
  assign bcnt_selected = !ctl_store_bit9 && ctl_store[dbadp_pkg::CS_BCNT_BIT]
                         && (ctl_store[1:0] == 2'b00);
  assign ext_status_only = !external_read_req_n;

  // Source select encoding
  always_comb begin
    if (st.cmd_pend) begin
      bus_source_select = dbadp_pkg::SEL_CMD_ADDR;
    end else if (ext_status_only) begin
      bus_source_select = dbadp_pkg::SEL_STATUS;
    end else if (int_read_req && !ctl_store_bit9) begin
      bus_source_select = dbadp_pkg::SEL_MAP;
    end else begin
      bus_source_select = ctl_store[2:0];
    end
  end

  dbadp_out_mux u_mux (
    .bus_source_select(bus_source_select),
    .ext_status_only(ext_status_only && !st.cmd_pend),
    .src(src),
    .byte_count_word({st.drive_cnt, st.mem_cnt}),
    .mux_out(mux_out)
  );

  // Drivers on only for read or command with send transfer
  // External status reads go out on the control path drivers
  assign bus_drive_en = (int_read_req || st.cmd_pend) && send_transfer;

  // Command condition
  logic read_case;
  logic write_case;
  // Neither direction flag set asks for nothing on a read
  logic full_forward_case;
  logic full_reverse_case;
  logic end_forward_case;
  logic end_reverse_case;
  logic end_partial;
  assign end_partial = st.mem_zero && out_partly_filled;
  assign full_forward_case = mode.xfer_forward && last_byte_full;
  assign full_reverse_case = mode.xfer_reverse && last_byte_full;
  assign end_forward_case = mode.xfer_forward && end_partial;
  assign end_reverse_case = mode.xfer_reverse && end_partial;
  assign read_case = mode.xfer_is_read && (full_forward_case
    || full_reverse_case || end_forward_case || end_reverse_case);
  assign write_case = !mode.xfer_is_read && !st.input_word_two_full
    && mem_read_pending_n && !st.mem_zero;
  assign cmd_condition = mode.transfer_busy && !mode.block_send_cmd
    && !st.cmd_pend && (read_case || write_case);

  // Input byte enable, latched address, no enable on read or T1
  logic fill_ok;
  assign fill_ok = !mode.xfer_is_read && !phase_t1;
  always_comb begin
    input_byte_enable_n = 8'hff;
    if (fill_ok) begin
      input_byte_enable_n[st.va_latch] = 1'b0;
    end
  end

  // Silo load on write: more bytes, buffer two full, room
  assign silo_load = fill_ok && !st.mem_zero && st.input_word_two_full
                     && (st.silo_cnt != 5'(dbadp_pkg::SILO_DEPTH));
  assign virt_addr_bump_n = !(silo_load || (mode.xfer_is_read && silo_pop));
  assign silo_full = st.silo_cnt == 5'(dbadp_pkg::SILO_DEPTH);
  assign silo_empty = st.silo_cnt == 5'h00;
  // Unpack quadword byte by latched address
  assign silo_din = mode.xfer_is_read ? drive_byte
    : (st.va_latch[2] ? byte_of(st.word_two, st.va_latch[1:0])
                      : byte_of(st.word_one, st.va_latch[1:0]));
  assign silo_push = silo_load || (mode.xfer_is_read && drive_byte_in
                     && !silo_full);
  // Silo keeps draining after a drive error
  assign silo_pop = out_byte_taken && !silo_empty;

  assign ebl_seen = st.ebl_sync[1] == st.ebl_sync[2] && st.ebl_sync[2];

  always_comb begin
    next_st = st;
    next_st.ebl_sync = {st.ebl_sync[1:0], end_of_block};
    // Byte latches on input strobe
    if (bus_input_strobe) begin
      for (int i = 0; i < 4; i++) begin
        next_st.rx_latch[i*8 +: 8] = bus_in[i*8 +: 8];
      end
    end
    if (load_word_one) begin
      next_st.word_one = st.rx_latch;
    end
    if (load_word_two) begin
      next_st.word_two = st.rx_latch;
      next_st.input_word_two_full = 1'b1;
      if (st.fill_cnt != dbadp_pkg::FILL_EMPTY) begin
        next_st.fill_cnt = st.fill_cnt - 4'h1;
      end
    end
    if (mem_select_latch) begin
      next_st.va_latch = virt_addr_low;
    end
    // A fresh second word wins over the clear
    if (silo_load && st.va_latch == 3'h7 && !load_word_two) begin
      next_st.input_word_two_full = 1'b0;
    end
    // Counters
    if (count_write) begin
      next_st.mem_cnt = bus_in[15:0];
      next_st.drive_cnt = bus_in[15:0];
      next_st.mem_zero = 1'b0;
      next_st.drive_zero = 1'b0;
      next_st.done = 1'b0;
      next_st.run_clr = 1'b0;
    end else if (!mode.xfer_is_read) begin
      if (silo_load) begin
        {next_st.mem_zero, next_st.mem_cnt} =
          {1'b0, st.mem_cnt} + 17'h00001;
        if (st.mem_cnt == 16'hffff) begin
          next_st.mem_zero = 1'b1;
        end
      end
      if (drive_word_sent && !st.drive_zero) begin
        next_st.drive_cnt = st.drive_cnt - 16'h0002;
        if (st.drive_cnt == 16'h0002) begin
          next_st.drive_zero = 1'b1;
          next_st.run_clr = 1'b1;
        end
      end
      if (st.drive_zero && ebl_seen) begin
        next_st.done = 1'b1;
      end
    end else begin
      // Read direction counts
      if (silo_push && !st.drive_zero) begin
        next_st.drive_cnt = st.drive_cnt - 16'h0001;
        next_st.drive_zero = st.drive_cnt == 16'h0001;
      end
      if (silo_pop && !st.mem_zero) begin
        next_st.mem_cnt = st.mem_cnt - 16'h0001;
        next_st.mem_zero = st.mem_cnt == 16'h0001;
      end
      if (ebl_seen && st.mem_zero) begin
        next_st.done = 1'b1;
      end
    end
    // Pending command: set wins over accept
    if (cmd_condition) begin
      next_st.cmd_pend = 1'b1;
    end else if (cmd_accepted) begin
      next_st.cmd_pend = 1'b0;
    end
    // Silo bookkeeping
    if (silo_push) begin
      next_st.wr_ptr = st.wr_ptr + 4'h1;
    end
    if (silo_pop) begin
      next_st.rd_ptr = st.rd_ptr + 4'h1;
      next_st.silo_dout = silo_mem[st.rd_ptr];
    end
    next_st.silo_cnt = st.silo_cnt + 5'(silo_push) - 5'(silo_pop);
    if (bus_drive_en) begin
      next_st.bus_out = bcnt_selected && int_read_req
        ? {st.drive_cnt, st.mem_cnt} : mux_out;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (silo_push) begin
      silo_mem[st.wr_ptr] <= silo_din;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
      st.fill_cnt <= dbadp_pkg::FILL_PRESET;
      st.mem_cnt <= dbadp_pkg::CNT_RESET;
      st.drive_cnt <= dbadp_pkg::CNT_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign bus_out = st.bus_out;
  assign cmd_req_pending = st.cmd_pend;
  assign split_byte_count = {st.drive_cnt, st.mem_cnt};
  assign mem_count_zero_n = !st.mem_zero;
  assign drive_count_zero = st.drive_zero;
  assign run_clear = st.run_clr;
  assign xfer_done = st.done;
  assign write_buffers_ready = st.fill_cnt == dbadp_pkg::FILL_EMPTY;
  assign silo_out = st.silo_dout;
  assign silo_out_valid = !silo_empty;
endmodule : dbadp_data_path
`default_nettype wire

// ===== verilog/dbadp_pkg.sv
// Package of constants and carrier types for the drive bus adapter data path
`default_nettype none
package dbadp_pkg;
  localparam int unsigned CNT_W = 16;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [3:0] FILL_PRESET = 4'h4;
  localparam logic [3:0] FILL_EMPTY = 4'h0;
  localparam int unsigned SILO_DEPTH = 16;
  localparam int unsigned SILO_AW = 4;
  localparam int unsigned DRIVE_CNT_LSB = 16;
  localparam int unsigned MEM_CNT_LSB = 0;
  localparam int unsigned CS_SEL_BIT = 9;
  localparam int unsigned CS_BCNT_BIT = 2;
  localparam logic [2:0] SEL_CMD_ADDR = 3'h7;
  localparam logic [2:0] SEL_MAP = 3'h6;
  localparam logic [2:0] SEL_DIAG = 3'h5;
  localparam logic [2:0] SEL_SPLIT_BYTE_COUNT = 3'h4;
  localparam logic [2:0] SEL_VIRT_ADDR = 3'h3;
  localparam logic [2:0] SEL_STATUS = 3'h2;
  localparam logic [2:0] SEL_CONTROL = 3'h1;
  localparam logic [2:0] SEL_CONFIG = 3'h0;

  // Seven 32-bit sources and a 16-bit drive status feeding the bus output selector
  typedef struct packed {
    logic [31:0] cmd_addr;
    logic [31:0] map;
    logic [31:0] diag;
    logic [31:0] virt_addr;
    logic [31:0] status;
    logic [31:0] control;
    logic [31:0] config_reg;
    logic [15:0] drive_status_low;
  } dbadp_src_t;

  // Transfer mode flags
  typedef struct packed {
    logic transfer_busy;
    logic xfer_is_read;
    logic xfer_forward;
    logic xfer_reverse;
    logic block_send_cmd;
    logic drive_error;
  } dbadp_mode_t;
endpackage : dbadp_pkg
`default_nettype wire

// ===== verilog/dbadp_out_mux.sv
// Internal bus output selector, 32 eight-input multiplexers
`default_nettype none
module dbadp_out_mux (
  input wire logic [2:0] bus_source_select,
  input wire logic ext_status_only,
  input wire dbadp_pkg::dbadp_src_t src,
  input wire logic [31:0] byte_count_word,
  output logic [31:0] mux_out
);
  logic [31:0] in_word [8];

  always_comb begin
    in_word[0] = src.config_reg;
    in_word[1] = src.control;
    in_word[2] = src.status;
    in_word[3] = src.virt_addr;
    in_word[4] = byte_count_word;
    in_word[5] = src.diag;
    in_word[6] = src.map;
    in_word[7] = src.cmd_addr;
  end

  // One eight-way mux per bit
  for (genvar b = 0; b < 32; b++) begin : g_bit
    logic [7:0] bits;
    always_comb begin
      for (int k = 0; k < 8; k++) begin
        bits[k] = in_word[k][b];
      end
    end
    if (b < 16) begin : g_low
      // Low half from drive control path on external reads
      assign mux_out[b] = ext_status_only ? src.drive_status_low[b]
                                          : bits[bus_source_select];
    end else begin : g_high
      assign mux_out[b] = bits[bus_source_select];
    end
  end
endmodule : dbadp_out_mux
`default_nettype wire

// ===== dv/dbadp_chk.sv
// Port assertions for the drive bus adapter data path
`default_nettype none
module dbadp_chk (
  input wire logic ref_clk,
  input wire logic rst,
  input wire dbadp_pkg::dbadp_mode_t mode,
  input wire logic ctl_store_bit9,
  input wire logic int_read_req,
  input wire logic external_read_req_n,
  input wire logic send_transfer,
  input wire logic phase_t1,
  input wire logic count_write,
  input wire logic [31:0] bus_in,
  input wire logic bus_drive_en,
  input wire logic [2:0] bus_source_select,
  input wire logic cmd_condition,
  input wire logic cmd_req_pending,
  input wire logic [31:0] split_byte_count,
  input wire logic mem_count_zero_n,
  input wire logic [7:0] input_byte_enable_n,
  input wire logic silo_load
);
  logic [15:0] last_word;
  // Keeps the written value for the check one edge later
  always_ff @(posedge ref_clk) last_word <= bus_in[15:0];
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_sel_cmd: assert property (
    cmd_req_pending |-> bus_source_select == 3'h7)
    else $error("select not command");
  a_sel_map: assert property (
    !cmd_req_pending && int_read_req && !ctl_store_bit9
    |-> bus_source_select == 3'h6) else $error("select not map");
  a_sel_ext: assert property (
    !cmd_req_pending && !int_read_req && !external_read_req_n
    |-> bus_source_select == 3'h2) else $error("select not status");
  a_drive_en: assert property (
    bus_drive_en == ((int_read_req || cmd_req_pending) && send_transfer))
    else $error("bus drive enable wrong");
  a_cnt_copy: assert property (
    count_write |=> split_byte_count == {last_word, last_word})
    else $error("count copy wrong");
  a_cmd_gate: assert property (
    cmd_condition |-> mode.transfer_busy && !mode.block_send_cmd
    && !cmd_req_pending) else $error("memory request not gated");
  a_stop_load: assert property (
    !mem_count_zero_n |-> !silo_load) else $error("load after count zero");
  a_no_enable: assert property (
    phase_t1 || mode.xfer_is_read |-> input_byte_enable_n == 8'hff)
    else $error("input byte enabled");
endmodule : dbadp_chk
bind dbadp_data_path dbadp_chk u_chk (.*);
`default_nettype wire

// ===== dv/dbadp_mem_model.sv
// Memory side responder: grants a request, then sends two data words
`default_nettype none
module dbadp_mem_model #(
  parameter int DELAY = 1
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic cmd_req_pending,
  input wire logic [31:0] host_word,
  output logic cmd_accepted,
  output logic mem_read_pending_n,
  output logic bus_input_strobe,
  output logic load_word_one,
  output logic load_word_two,
  output logic [31:0] bus_in,
  output var int n_two
);
  timeunit 1ns;
  timeprecision 1ps;
  int step;
  logic [31:0] word;
  // Idle bus shows the host word, never a stale memory word
  assign bus_in = bus_input_strobe ? word : host_word;
  always @(negedge ref_clk or posedge rst) begin
    if (rst) begin
      step <= 0;
      word <= 32'h0;
      n_two <= 0;
      mem_read_pending_n <= 1'h1;
      {cmd_accepted, bus_input_strobe, load_word_one, load_word_two} <= 4'h0;
    end else begin
      {cmd_accepted, bus_input_strobe, load_word_one, load_word_two} <= 4'h0;
      if (step == 0) step <= int'(cmd_req_pending);
      else if (step < DELAY) step <= step + 1;
      else begin
        step <= (step == DELAY + 5) ? 0 : step + 1;
        case (step - DELAY)
          0: begin
            cmd_accepted <= 1'h1;
            mem_read_pending_n <= 1'h0;
          end
          1, 3: begin
            word <= word + 32'h04040404;
            bus_input_strobe <= 1'h1;
          end
          2: load_word_one <= 1'h1;
          4: begin
            load_word_two <= 1'h1;
            n_two <= n_two + 1;
          end
          default: mem_read_pending_n <= 1'h1;
        endcase
      end
    end
  end
endmodule : dbadp_mem_model
`default_nettype wire

// ===== dv/tb.sv
// Self-checking bench for the data path
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic t1, rd, ext_n;
    logic [3:0] cs;
    logic [2:0] va, sel;
    logic [7:0] en_n;
  } dbadp_row_t;
  dbadp_row_t rows [9] = '{
    '{1'h0, 1'h1, 1'h1, 4'h0, 3'h0, 3'h6, 8'hfe},
    '{1'h0, 1'h1, 1'h1, 4'hd, 3'h1, 3'h5, 8'hfd},
    '{1'h0, 1'h1, 1'h1, 4'hc, 3'h2, 3'h4, 8'hfb},
    '{1'h0, 1'h1, 1'h1, 4'hb, 3'h3, 3'h3, 8'hf7},
    '{1'h0, 1'h1, 1'h1, 4'ha, 3'h4, 3'h2, 8'hef},
    '{1'h0, 1'h1, 1'h1, 4'h9, 3'h5, 3'h1, 8'hdf},
    '{1'h0, 1'h1, 1'h1, 4'h8, 3'h6, 3'h0, 8'hbf},
    '{1'h0, 1'h0, 1'h0, 4'h8, 3'h7, 3'h2, 8'h7f},
    '{1'h1, 1'h1, 1'h1, 4'h0, 3'h3, 3'h6, 8'hff}};
  logic ref_clk = 1'h0, rst = 1'h1, int_read_req = 1'h0;
  logic external_read_req_n = 1'h1, send_transfer = 1'h0, phase_t1 = 1'h0;
  logic count_write = 1'h0, mem_select_latch = 1'h0, end_of_block = 1'h0;
  logic drive_word_sent = 1'h0, drive_byte_in = 1'h0, out_byte_taken = 1'h0;
  logic last_byte_full = 1'h0, out_partly_filled = 1'h0, auto_va = 1'h0;
  logic [2:0] virt_addr_low = 3'h0, bus_source_select;
  logic [9:0] ctl_store = 10'h000;
  logic [31:0] host_word = 32'h0, bus_in, split_byte_count, bus_out;
  dbadp_pkg::dbadp_mode_t mode = '0;
  logic cmd_accepted, mem_read_pending_n, bus_input_strobe, load_word_one;
  logic load_word_two, bus_drive_en, cmd_condition, cmd_req_pending;
  logic mem_count_zero_n, drive_count_zero, run_clear, xfer_done;
  logic write_buffers_ready, virt_addr_bump_n, silo_load, silo_empty;
  logic [7:0] input_byte_enable_n, silo_out;
  int n_two, n_fail = 0, compares = 0, n_load = 0;
  dbadp_mem_model #(.DELAY(2)) u_mem (.*);
  dbadp_data_path u_dut (.ctl_store_bit9(ctl_store[9]), .src('0),
    .drive_byte(8'h5a), .silo_out_valid(),
    .silo_full(), .*);
  initial forever #2 ref_clk = ~ref_clk;
  // Stands in for the address register that the bump pulse advances
  always @(negedge ref_clk)
    if (auto_va && !virt_addr_bump_n) virt_addr_low <= virt_addr_low + 3'h1;
  always @(posedge ref_clk) if (silo_load) n_load++;
  task automatic pulse(ref logic s);
    s = 1'h1;
    @(negedge ref_clk);
    s = 1'h0;
    @(negedge ref_clk);
  endtask : pulse
  task automatic chk_rst;
    `CHK("cnt", 32'h0, split_byte_count)
    `CHK("pend", 1'h0, cmd_req_pending)
    `CHK("dzero", 1'h0, drive_count_zero)
    `CHK("ready", 1'h0, write_buffers_ready)
  endtask : chk_rst
  task automatic end_sim;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim
  initial begin
    #80000;
    n_fail++;
    end_sim();
  end
  initial begin
    repeat (12) @(negedge ref_clk);
    rst = 1'h0;
    @(negedge ref_clk);
    chk_rst();
    $display("reset test done");
    send_transfer = 1'h1;
    mem_select_latch = 1'h1;
    foreach (rows[i]) begin
      phase_t1 = rows[i].t1;
      int_read_req = rows[i].rd;
      external_read_req_n = rows[i].ext_n;
      ctl_store = {rows[i].cs[3], 6'h00, rows[i].cs[2:0]};
      virt_addr_low = rows[i].va;
      @(negedge ref_clk);
      `CHK("sel", rows[i].sel, bus_source_select)
      `CHK("en", rows[i].en_n, input_byte_enable_n)
      `CHK("drv", rows[i].rd, bus_drive_en)
    end
    {int_read_req, external_read_req_n, send_transfer, phase_t1} = 4'h4;
    mem_select_latch = 1'h0;
    $display("decode test done");
    // Blocked so that no memory traffic disturbs the counts
    mode.transfer_busy = 1'h1;
    mode.block_send_cmd = 1'h1;
    host_word = 32'h4;
    pulse(count_write);
    `CHK("copy", 32'h00040004, split_byte_count)
    pulse(drive_word_sent);
    `CHK("dcnt", 16'h2, split_byte_count[31:16])
    pulse(drive_word_sent);
    @(negedge ref_clk);
    `CHK("dzero", 1'h1, drive_count_zero)
    `CHK("run", 1'h1, run_clear)
    mode.xfer_is_read = 1'h1;
    mode.xfer_forward = 1'h1;
    host_word = 32'h2;
    pulse(count_write);
    pulse(drive_byte_in);
    pulse(drive_byte_in);
    `CHK("dcnt", 16'h0, split_byte_count[31:16])
    end_of_block = 1'h1;
    repeat (6) @(negedge ref_clk);
    `CHK("done", 1'h0, xfer_done)
    pulse(out_byte_taken);
    `CHK("silo", 8'h5a, silo_out)
    pulse(out_byte_taken);
    `CHK("mcnt", 16'h0, split_byte_count[15:0])
    for (int k = 0; k < 8 && xfer_done !== 1'h1; k++) @(negedge ref_clk);
    `CHK("done", 1'h1, xfer_done)
    end_of_block = 1'h0;
    mode.block_send_cmd = 1'h0;
    last_byte_full = 1'h1;
    #0.4;
    `CHK("cond", 1'h1, cmd_condition)
    last_byte_full = 1'h0;
    #0.4;
    `CHK("cond", 1'h0, cmd_condition)
    out_partly_filled = 1'h1;
    mode.drive_error = 1'h1;
    #0.4;
    `CHK("cond", 1'h1, cmd_condition)
    mode.block_send_cmd = 1'h1;
    #0.4;
    `CHK("cond", 1'h0, cmd_condition)
    @(negedge ref_clk);
    out_partly_filled = 1'h0;
    mode = '0;
    $display("count test done");
    host_word = 32'hffe0;
    pulse(count_write);
    n_load = 0;
    auto_va = 1'h1;
    mem_select_latch = 1'h1;
    virt_addr_low = 3'h0;
    mode.transfer_busy = 1'h1;
    for (int k = 0; k < 600 && mem_count_zero_n !== 1'h0; k++) begin
      @(negedge ref_clk);
      out_byte_taken = !silo_empty;
    end
    out_byte_taken = 1'h0;
    repeat (12) @(negedge ref_clk);
    `CHK("loads", 32'h20, n_load)
    `CHK("mcnt", 16'h0, split_byte_count[15:0])
    `CHK("reads", 32'h4, n_two)
    `CHK("ready", 1'h1, write_buffers_ready)
    `CHK("addr", 3'h0, virt_addr_low)
    auto_va = 1'h0;
    mode = '0;
    mem_select_latch = 1'h0;
    ctl_store = 10'h204;
    {int_read_req, send_transfer} = 2'h3;
    @(negedge ref_clk);
    `CHK("bus", 32'hffe00000, bus_out)
    ctl_store = 10'h203;
    @(negedge ref_clk);
    `CHK("bus", 32'h0, bus_out)
    ctl_store = 10'h004;
    @(negedge ref_clk);
    `CHK("bus", 32'hffe00000, bus_out)
    {int_read_req, send_transfer} = 2'h0;
    ctl_store = 10'h000;
    $display("fill test done");
    rst = 1'h1;
    @(negedge ref_clk);
    rst = 1'h0;
    @(negedge ref_clk);
    chk_rst();
    $display("second reset test done");
    end_sim();
  end
endmodule : tb
`default_nettype wire
